// *** core/key_port_ctrl.sv ***
// Key-scan, key-input and sense ports with carrier/prescale control, AXI4-Lite register slave
//
// Contract
// - Key-scan read gives pin levels in input mode, latch contents in output mode.
// - Key-scan write with byte lane 0 strobed updates the output latch in either mode.
// - Reset puts key-scan port in output mode with latch all ones.
// - Key-scan direction follows pin-mode bit 1; one means output.
// - Key-scan pull-downs active only in input mode.
// - Key-sense bits 7..4 read key input pins, read-only; bits 1..0 read one.
// - Key input pull-downs switch together by pin-mode bit 5, on after reset.
// - Sense bit reads pin in input mode, one in off mode with buffer off.
// - Sense mode follows pin-mode bit 0; reset selects off mode, high impedance.
// - Pin-mode bit 4 enables sense and indicator pull-downs, only in input mode.
// - Key-sense bit 3 reads the indicator pin in both modes, read-only.
// - Indicator direction follows pin-mode bit 2; output mode shows timer state, no pull-down.
// - Reset puts indicator pin in output mode driving high.
// - Carrier control resets to 03h; bits 7 and 6 stay zero.
// - Carrier control bit 2 clear modulates drive with carrier; set gives steady high.
// - Carrier control bit 3 picks timer clock divide 8 or 16, halves the carrier.
// - With bit 3 clear codes give osc, div8, div12 half duty, div12 third duty.
// - With bit 3 set codes give div2, div16, div24 half duty, div24 third duty.
// - Carrier control bits 5..4 supply ROM pointer address bits 9..8.
// - Pin-mode register resets to 26h; bits 7, 6 and 3 stay zero.
// - Every pull-down is off while its pin is in output or off mode.
module key_port_ctrl
	import key_port_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	// AXI4-Lite write response
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] AXI_ARADDR_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	// Key-scan pins
	input wire logic [7:0] KEY_SCAN_PINS_I,
	output logic [7:0] KEY_SCAN_PINS_O,
	output logic KEY_SCAN_PINS_OE_O,
	output logic KEY_SCAN_PD_O,
	// Key input pins
	input wire logic [3:0] KEY_INPUT_PINS_I,
	output logic KEY_INPUT_PD_O,
	// Sense pin
	input wire logic SENSE_PIN_I,
	output logic SENSE_PIN_EN_O,
	output logic SENSE_PIN_PD_O,
	// Sense/indicator pin
	input wire logic SENSE_INDICATOR_PIN_I,
	output logic SENSE_INDICATOR_PIN_O,
	output logic SENSE_INDICATOR_PIN_OE_O,
	output logic SENSE_INDICATOR_PD_O,
	// Timer side
	input wire logic TIMER_RUN_I,
	input wire logic TIMER_OUT_EN_I,
	output logic TIMER_TICK_O,
	output logic [1:0] ROM_POINTER_HI_O,
	output logic CARRIER_O,
	output logic INFRARED_DRIVE_O
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// One-hot register select; all zero means unmapped
	function automatic logic [4:0] decode_reg(input logic [ADDR_W-1:0] addr);
		logic [4:0] sel;
		sel = 5'h00;
		case (addr)
			KEY_SCAN_PORT_REG_OFS: sel = 5'h01;
			KEY_SENSE_INPUT_REG_OFS: sel = 5'h02;
			CARRIER_TIMER_CONTROL_REG_OFS: sel = 5'h04;
			PIN_MODE_CONTROL_REG_OFS: sel = 5'h08;
			CARRIER_STATUS_REG_OFS: sel = 5'h10;
			default: sel = 5'h00;
		endcase
		return sel;
	endfunction

	// Carrier period in core clocks
	function automatic logic [5:0] carr_period(input logic [1:0] code, input logic halve);
		logic [5:0] p;
		case (code)
			2'h0: p = CARR_PER_OSC;
			2'h1: p = CARR_PER_DIV8;
			default: p = CARR_PER_DIV12;
		endcase
		return halve ? {p[4:0], 1'b0} : p;
	endfunction

	// Carrier high time in core clocks
	function automatic logic [5:0] carr_high(input logic [1:0] code, input logic halve);
		logic [5:0] h;
		case (code)
			2'h0: h = {1'b0, CARR_PER_OSC[5:1]};
			2'h1: h = {1'b0, CARR_PER_DIV8[5:1]};
			2'h2: h = {1'b0, CARR_PER_DIV12[5:1]};
			default: h = CARR_HIGH_THIRD_DIV12;
		endcase
		return halve ? {h[4:0], 1'b0} : h;
	endfunction

	// Pull-down only while the pin listens; output and off mode always drop it
	function automatic logic pd_gate(input logic pd_en, input logic listening);
		return pd_en && listening;
	endfunction

	// Reset image of all state
	function automatic core_state_s reset_state();
		core_state_s r;
		// Sense starts in off mode and every pull-down but the key inputs starts disconnected
		r = '0;
		r.scan_latch = KEY_SCAN_PORT_RST;
		r.ctl0 = CARRIER_TIMER_CONTROL_RST;
		r.ctl1 = PIN_MODE_CONTROL_RST;
		r.carrier = 1'b1;
		r.wr_st = WR_COLLECT;
		r.rd_st = RD_IDLE;
		r.awready = 1'b1;
		r.wready = 1'b1;
		r.arready = 1'b1;
		r.scan_oe = 1'b1;
		r.key_input_pd = 1'b1;
		r.ind_o = 1'b1;
		r.ind_oe = 1'b1;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	core_state_s st_r;
	core_state_s st_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic scan_out;
		logic sense_in;
		logic ind_out;
		logic halve;
		logic cdis;
		logic [1:0] code;
		logic [5:0] per;
		logic [5:0] tick_per;
		logic led_on;
		logic [4:0] wsel;
		logic [4:0] rsel;
		logic [7:0] ksi;

		scan_out = 1'b0;
		sense_in = 1'b0;
		ind_out = 1'b0;
		halve = 1'b0;
		cdis = 1'b0;
		code = 2'h0;
		per = 6'h00;
		tick_per = 6'h00;
		led_on = 1'b0;
		wsel = 5'h00;
		rsel = 5'h00;
		ksi = 8'h00;

		st_nxt = st_r;

		// Pin synchroniser: a level counts once stages two and three agree
		st_nxt.pin_s1 = {SENSE_INDICATOR_PIN_I, SENSE_PIN_I, KEY_INPUT_PINS_I, KEY_SCAN_PINS_I};
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.pin_s3 = st_r.pin_s2;
		st_nxt.pin_val = (st_r.pin_s2 & st_r.pin_s3) | (st_r.pin_val & (st_r.pin_s2 ^ st_r.pin_s3));

		// Mode decode from current control registers
		sense_in = st_r.ctl1[CTL1_SENSE_MODE_BIT];
		scan_out = st_r.ctl1[CTL1_SCAN_MODE_BIT];
		ind_out = st_r.ctl1[CTL1_INDICATOR_MODE_BIT];
		halve = st_r.ctl0[CTL0_PRESCALE_HALVING_BIT];
		cdis = st_r.ctl0[CTL0_CARRIER_DISABLE_BIT];
		code = st_r.ctl0[CTL0_SEL_LSB +: 2];

		// Key-sense image; off-mode sense reads one so a floating pin cannot leak in
		ksi[KSI_KEY_INPUT_LSB +: 4] = st_r.pin_val[PIN_KEY_INPUT_LSB +: 4];
		ksi[KSI_INDICATOR_BIT] = st_r.pin_val[PIN_INDICATOR];
		ksi[KSI_SENSE_BIT] = sense_in ? st_r.pin_val[PIN_SENSE] : 1'b1;
		ksi[1:0] = KEY_SENSE_FIXED_ONES;

		////////////////////////////////////////////////////////////////////////////////
		// Write channel: address and data taken in either order, response after both
		case (st_r.wr_st)
			WR_COLLECT: begin
				if (AXI_AWVALID_I && st_r.awready) begin
					st_nxt.aw_have = 1'b1;
					st_nxt.aw_addr = AXI_AWADDR_I;
				end

				if (AXI_WVALID_I && st_r.wready) begin
					st_nxt.w_have = 1'b1;
					st_nxt.w_data = AXI_WDATA_I[7:0];
					st_nxt.w_lane0 = AXI_WSTRB_I[0];
				end

				if (st_nxt.aw_have && st_nxt.w_have) begin
					wsel = decode_reg(st_nxt.aw_addr);
					st_nxt.bresp = (wsel == 5'h00) ? RESP_SLVERR : RESP_OKAY;
					// Lane 0 off still answers OKAY but stores nothing
					if (st_nxt.w_lane0) begin
						if (wsel[0]) begin
							st_nxt.scan_latch = st_nxt.w_data;
						end
						if (wsel[2]) begin
							st_nxt.ctl0 = st_nxt.w_data & CARRIER_TIMER_CONTROL_MASK;
						end
						if (wsel[3]) begin
							st_nxt.ctl1 = st_nxt.w_data & PIN_MODE_CONTROL_MASK;
						end
					end
					st_nxt.aw_have = 1'b0;
					st_nxt.w_have = 1'b0;
					st_nxt.wr_st = WR_RESP;
				end
			end
			WR_RESP: begin
				if (AXI_BREADY_I) begin
					st_nxt.wr_st = WR_COLLECT;
				end
			end
			default: begin
				st_nxt.wr_st = WR_COLLECT;
			end
		endcase
		st_nxt.bvalid = (st_nxt.wr_st == WR_RESP);
		st_nxt.awready = (st_nxt.wr_st == WR_COLLECT) && !st_nxt.aw_have;
		st_nxt.wready = (st_nxt.wr_st == WR_COLLECT) && !st_nxt.w_have;

		////////////////////////////////////////////////////////////////////////////////
		// Read channel: one beat, data taken from the state before this edge's writes
		case (st_r.rd_st)
			RD_IDLE: begin
				if (AXI_ARVALID_I && st_r.arready) begin
					rsel = decode_reg(AXI_ARADDR_I);
					st_nxt.rdata = 32'h0000_0000;
					// Unmapped reads answer SLVERR with zero data
					st_nxt.rresp = (rsel == 5'h00) ? RESP_SLVERR : RESP_OKAY;
					if (rsel[0]) begin
						st_nxt.rdata[7:0] = scan_out ? st_r.scan_latch : st_r.pin_val[PIN_SCAN_LSB +: 8];
					end
					if (rsel[1]) begin
						st_nxt.rdata[7:0] = ksi;
					end
					if (rsel[2]) begin
						st_nxt.rdata[7:0] = st_r.ctl0;
					end
					if (rsel[3]) begin
						st_nxt.rdata[7:0] = st_r.ctl1;
					end
					if (rsel[4]) begin
						st_nxt.rdata[2:0] = {st_r.tick, st_r.ir_drive, st_r.carrier};
					end
					st_nxt.rd_st = RD_RESP;
				end
			end
			RD_RESP: begin
				if (AXI_RREADY_I) begin
					st_nxt.rd_st = RD_IDLE;
				end
			end
			default: begin
				st_nxt.rd_st = RD_IDLE;
			end
		endcase
		st_nxt.rvalid = (st_nxt.rd_st == RD_RESP);
		st_nxt.arready = (st_nxt.rd_st == RD_IDLE);

		////////////////////////////////////////////////////////////////////////////////
		// Timer clock prescaler: one-cycle tick each 8 or 16 oscillator periods
		tick_per = halve ? {TIMER_TICK_CYC[4:0], 1'b0} : TIMER_TICK_CYC;
		if (st_r.tick_cnt >= tick_per - 6'h01) begin
			st_nxt.tick_cnt = 6'h00;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + 6'h01;
			st_nxt.tick = 1'b0;
		end

		// Carrier generator runs free; a code change restarts a cycle at the wrap
		per = carr_period(code, halve);
		if (st_r.carr_cnt >= per - 6'h01) begin
			st_nxt.carr_cnt = 6'h00;
		end else begin
			st_nxt.carr_cnt = st_r.carr_cnt + 6'h01;
		end
		st_nxt.carrier = (st_nxt.carr_cnt < carr_high(code, halve));

		// Drive: while the timer runs with output enabled, carrier or steady high; on stop, finish the carrier high phase, steady high ends at once
		led_on = TIMER_RUN_I && TIMER_OUT_EN_I;
		if (led_on) begin
			// Drive takes the next carrier value so it never lags the carrier output
			st_nxt.ir_drive = cdis ? 1'b1 : st_nxt.carrier;
		end else begin
			st_nxt.ir_drive = st_r.ir_drive && !cdis && st_nxt.carrier;
		end

		////////////////////////////////////////////////////////////////////////////////
		// Pin drivers, pull-downs and input enable from the next control values
		st_nxt.scan_oe = st_nxt.ctl1[CTL1_SCAN_MODE_BIT];
		st_nxt.scan_pd = pd_gate(1'b1, !st_nxt.ctl1[CTL1_SCAN_MODE_BIT]);
		st_nxt.key_input_pd = st_nxt.ctl1[CTL1_KEY_INPUT_PD_BIT];
		st_nxt.sense_en = st_nxt.ctl1[CTL1_SENSE_MODE_BIT];
		st_nxt.sense_pd = pd_gate(st_nxt.ctl1[CTL1_SENSE_PD_BIT], st_nxt.ctl1[CTL1_SENSE_MODE_BIT]);
		st_nxt.ind_oe = st_nxt.ctl1[CTL1_INDICATOR_MODE_BIT];
		st_nxt.ind_pd = pd_gate(st_nxt.ctl1[CTL1_SENSE_PD_BIT], !st_nxt.ctl1[CTL1_INDICATOR_MODE_BIT]);
		st_nxt.ind_o = !led_on;
		if (ind_out) begin
			st_nxt.ind_o = !led_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register

	// Reset clears the pin stages too, so pin reads settle four edges after release
	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			st_r <= reset_state();
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a state bit

	assign AXI_AWREADY_O = st_r.awready;
	assign AXI_WREADY_O = st_r.wready;
	assign AXI_BRESP_O = st_r.bresp;
	assign AXI_BVALID_O = st_r.bvalid;
	assign AXI_ARREADY_O = st_r.arready;
	assign AXI_RDATA_O = st_r.rdata;
	assign AXI_RRESP_O = st_r.rresp;
	assign AXI_RVALID_O = st_r.rvalid;

	assign KEY_SCAN_PINS_O = st_r.scan_latch;
	assign KEY_SCAN_PINS_OE_O = st_r.scan_oe;
	assign KEY_SCAN_PD_O = st_r.scan_pd;
	assign KEY_INPUT_PD_O = st_r.key_input_pd;
	assign SENSE_PIN_EN_O = st_r.sense_en;
	assign SENSE_PIN_PD_O = st_r.sense_pd;
	assign SENSE_INDICATOR_PIN_O = st_r.ind_o;
	assign SENSE_INDICATOR_PIN_OE_O = st_r.ind_oe;
	assign SENSE_INDICATOR_PD_O = st_r.ind_pd;

	assign TIMER_TICK_O = st_r.tick;
	assign ROM_POINTER_HI_O = st_r.ctl0[CTL0_ROM_POINTER_LSB +: 2];
	assign CARRIER_O = st_r.carrier;
	assign INFRARED_DRIVE_O = st_r.ir_drive;

endmodule // key_port_ctrl

// *** pkg/key_port_pkg.sv ***
// Package: register map, field layout, reset values, timing counts and state types of the key port block
package key_port_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus geometry and register offsets (byte addresses, one word each)
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] KEY_SCAN_PORT_REG_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] KEY_SENSE_INPUT_REG_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] CARRIER_TIMER_CONTROL_REG_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] PIN_MODE_CONTROL_REG_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] CARRIER_STATUS_REG_OFS = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and writable masks
	localparam logic [7:0] KEY_SCAN_PORT_RST = 8'hFF;
	localparam logic [7:0] CARRIER_TIMER_CONTROL_RST = 8'h03;
	localparam logic [7:0] PIN_MODE_CONTROL_RST = 8'h26;
	localparam logic [7:0] CARRIER_TIMER_CONTROL_MASK = 8'h3F;
	localparam logic [7:0] PIN_MODE_CONTROL_MASK = 8'h37;
	localparam logic [1:0] KEY_SENSE_FIXED_ONES = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTL0_SEL_LSB = 0;
	localparam int CTL0_CARRIER_DISABLE_BIT = 2;
	localparam int CTL0_PRESCALE_HALVING_BIT = 3;
	localparam int CTL0_ROM_POINTER_LSB = 4;
	localparam int CTL1_SENSE_MODE_BIT = 0;
	localparam int CTL1_SCAN_MODE_BIT = 1;
	localparam int CTL1_INDICATOR_MODE_BIT = 2;
	localparam int CTL1_SENSE_PD_BIT = 4;
	localparam int CTL1_KEY_INPUT_PD_BIT = 5;
	localparam int KSI_SENSE_BIT = 2;
	localparam int KSI_INDICATOR_BIT = 3;
	localparam int KSI_KEY_INPUT_LSB = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Pin image layout after synchronisation
	localparam int PIN_W = 14;
	localparam int PIN_SCAN_LSB = 0;
	localparam int PIN_KEY_INPUT_LSB = 8;
	localparam int PIN_SENSE = 12;
	localparam int PIN_INDICATOR = 13;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: core clocks per oscillator period, dividers in oscillator periods
	localparam int CLK_PER_OSC = 2;
	localparam int TIMER_DIV = 8;
	localparam int CARR_DIV_OSC = 1;
	localparam int CARR_DIV_8 = 8;
	localparam int CARR_DIV_12 = 12;
	localparam logic [5:0] TIMER_TICK_CYC = 6'(TIMER_DIV * CLK_PER_OSC);
	localparam logic [5:0] CARR_PER_OSC = 6'(CARR_DIV_OSC * CLK_PER_OSC);
	localparam logic [5:0] CARR_PER_DIV8 = 6'(CARR_DIV_8 * CLK_PER_OSC);
	localparam logic [5:0] CARR_PER_DIV12 = 6'(CARR_DIV_12 * CLK_PER_OSC);
	localparam logic [5:0] CARR_HIGH_THIRD_DIV12 = 6'(CARR_DIV_12 * CLK_PER_OSC / 3);

	////////////////////////////////////////////////////////////////////////////////
	// State types
	typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} wr_state_e;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_e;

	typedef struct packed {
		logic [7:0] scan_latch;
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic [PIN_W-1:0] pin_s1;
		logic [PIN_W-1:0] pin_s2;
		logic [PIN_W-1:0] pin_s3;
		logic [PIN_W-1:0] pin_val;
		logic [5:0] carr_cnt;
		logic carrier;
		logic ir_drive;
		logic [5:0] tick_cnt;
		logic tick;
		wr_state_e wr_st;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] aw_addr;
		logic [7:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		rd_state_e rd_st;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic scan_oe;
		logic scan_pd;
		logic key_input_pd;
		logic sense_en;
		logic sense_pd;
		logic ind_o;
		logic ind_oe;
		logic ind_pd;
	} core_state_s;

endpackage

// *** testbench/key_port_monitor.sv ***
// Checker of port, timer tick and bus timing relations of the key port block
module key_port_monitor
	import key_port_pkg::*;
(
	// Clock, reset and bus
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire logic [ADDR_W-1:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	input wire logic AXI_AWREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	input wire logic AXI_WREADY_O,
	input wire logic AXI_BVALID_O,
	input wire logic AXI_ARVALID_I,
	input wire logic AXI_ARREADY_O,
	input wire logic [31:0] AXI_RDATA_O,
	input wire logic AXI_RVALID_O,
	// Pins and timer side
	input wire logic [7:0] KEY_SCAN_PINS_O,
	input wire logic KEY_SCAN_PINS_OE_O,
	input wire logic KEY_SCAN_PD_O,
	input wire logic SENSE_PIN_EN_O,
	input wire logic SENSE_PIN_PD_O,
	input wire logic SENSE_INDICATOR_PIN_O,
	input wire logic SENSE_INDICATOR_PIN_OE_O,
	input wire logic SENSE_INDICATOR_PD_O,
	input wire logic TIMER_RUN_I,
	input wire logic TIMER_OUT_EN_I,
	input wire logic TIMER_TICK_O,
	input wire logic [1:0] ROM_POINTER_HI_O
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr_go;
	// Only same-edge address and data takes are judged; the bench always offers both together
	assign wr_go = AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O && AXI_WSTRB_I[0];
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	////////////////////////////////////////////////////////////
	a_scan_pd_mode: assert property (KEY_SCAN_PD_O == !KEY_SCAN_PINS_OE_O)
		else $error("scan pull-down not tied to input mode");
	a_sense_pd_off: assert property (SENSE_PIN_PD_O |-> SENSE_PIN_EN_O)
		else $error("sense pull-down on in off mode");
	a_ind_pd_out: assert property (SENSE_INDICATOR_PD_O |-> !SENSE_INDICATOR_PIN_OE_O)
		else $error("indicator pull-down on in output mode");
	a_ind_timer_low: assert property (TIMER_RUN_I && TIMER_OUT_EN_I |=> !SENSE_INDICATOR_PIN_O)
		else $error("indicator not low while timer runs");
	a_scan_latch_wr: assert property (wr_go && AXI_AWADDR_I == KEY_SCAN_PORT_REG_OFS
		|=> KEY_SCAN_PINS_O == $past(AXI_WDATA_I[7:0]))
		else $error("scan latch not written");
	a_scan_dir_wr: assert property (wr_go && AXI_AWADDR_I == PIN_MODE_CONTROL_REG_OFS
		|=> KEY_SCAN_PINS_OE_O == $past(AXI_WDATA_I[1]))
		else $error("scan direction not following mode bit");
	a_rom_ptr_wr: assert property (wr_go && AXI_AWADDR_I == CARRIER_TIMER_CONTROL_REG_OFS
		|=> ROM_POINTER_HI_O == $past(AXI_WDATA_I[5:4]))
		else $error("pointer bits not following control bits");
	a_tick_gap: assert property (TIMER_TICK_O |=> !TIMER_TICK_O [*8])
		else $error("timer ticks too close");
	a_read_answer: assert property (AXI_ARVALID_I && AXI_ARREADY_O
		|=> AXI_RVALID_O && AXI_RDATA_O[31:8] == 24'h000000)
		else $error("read answer late or wide");
	a_write_answer: assert property (wr_go |=> AXI_BVALID_O ##0 !AXI_AWREADY_O && !AXI_WREADY_O)
		else $error("write answer late or not refusing");
	c_mode_write: cover property (wr_go && AXI_AWADDR_I == PIN_MODE_CONTROL_REG_OFS);
	c_tick: cover property (TIMER_TICK_O);
	c_timer_run: cover property (TIMER_RUN_I && TIMER_OUT_EN_I);
endmodule // key_port_monitor

bind key_port_ctrl key_port_monitor key_port_monitor_i (.CORE_CLK_I, .RSTN_I, .AXI_AWADDR_I,
	.AXI_AWVALID_I, .AXI_AWREADY_O, .AXI_WDATA_I, .AXI_WSTRB_I, .AXI_WVALID_I, .AXI_WREADY_O,
	.AXI_BVALID_O, .AXI_ARVALID_I, .AXI_ARREADY_O, .AXI_RDATA_O, .AXI_RVALID_O, .KEY_SCAN_PINS_O,
	.KEY_SCAN_PINS_OE_O, .KEY_SCAN_PD_O, .SENSE_PIN_EN_O, .SENSE_PIN_PD_O, .SENSE_INDICATOR_PIN_O,
	.SENSE_INDICATOR_PIN_OE_O, .SENSE_INDICATOR_PD_O, .TIMER_RUN_I, .TIMER_OUT_EN_I, .TIMER_TICK_O,
	.ROM_POINTER_HI_O);

// *** testbench/key_pad_model.sv ***
// Model of the key matrix, sense switches and indicator pin wiring
module key_pad_model (
	// Block pin drivers
	input wire logic clk_i,
	input wire logic [7:0] scan_o_i,
	input wire logic scan_oe_i,
	input wire logic scan_pd_i,
	input wire logic ind_o_i,
	input wire logic ind_oe_i,
	input wire logic sense_en_i,
	// Switch states
	input wire logic [7:0] scan_key_i,
	input wire logic sense_key_i,
	input wire logic ind_key_i,
	// Pin levels
	output logic [7:0] scan_pin_o,
	output logic sense_pin_o,
	output logic ind_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_r = 8'h00;
	// Undriven scan and sense lines toggle so a lost pull-down or buffer gate is not hidden by a settled level
	always @(posedge clk_i) float_r <= ~float_r;
	assign scan_pin_o = scan_oe_i ? scan_o_i : (scan_key_i | (scan_pd_i ? 8'h00 : float_r));
	assign sense_pin_o = sense_en_i ? sense_key_i : float_r[0];
	assign ind_pin_o = ind_oe_i ? ind_o_i : ind_key_i;
endmodule // key_pad_model

// *** testbench/tb_key_port_ctrl.sv ***
// Self-checking bench of the key port block
module tb_key_port_ctrl
	import key_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rstn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, scan_key = 8'h00, scan_i, scan_o;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, scan_oe, scan_pd, kin_pd, tick, carrier, drive;
	logic sense_i, sense_en, sense_pd, ind_i, ind_o, ind_oe, ind_pd;
	logic sense_key = 1'h0, ind_key = 1'h0, run = 1'h0, oen = 1'h0;
	logic [1:0] bresp, rresp, rom_hi;
	logic [3:0] kin = 4'hA;
	int err_count = 0, checked = 0;
	always #2.5 clk = ~clk;
	key_port_ctrl key_port_ctrl_i (.CORE_CLK_I(clk), .RSTN_I(rstn), .AXI_AWADDR_I(awaddr),
		.AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hF),
		.AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid),
		.AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
		.AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
		.KEY_SCAN_PINS_I(scan_i), .KEY_SCAN_PINS_O(scan_o), .KEY_SCAN_PINS_OE_O(scan_oe),
		.KEY_SCAN_PD_O(scan_pd), .KEY_INPUT_PINS_I(kin), .KEY_INPUT_PD_O(kin_pd), .SENSE_PIN_I(sense_i),
		.SENSE_PIN_EN_O(sense_en), .SENSE_PIN_PD_O(sense_pd), .SENSE_INDICATOR_PIN_I(ind_i),
		.SENSE_INDICATOR_PIN_O(ind_o), .SENSE_INDICATOR_PIN_OE_O(ind_oe), .SENSE_INDICATOR_PD_O(ind_pd),
		.TIMER_RUN_I(run), .TIMER_OUT_EN_I(oen), .TIMER_TICK_O(tick), .ROM_POINTER_HI_O(rom_hi),
		.CARRIER_O(carrier), .INFRARED_DRIVE_O(drive));
	key_pad_model key_pad_model_i (.clk_i(clk), .scan_o_i(scan_o), .scan_oe_i(scan_oe), .scan_pd_i(scan_pd),
		.ind_o_i(ind_o), .ind_oe_i(ind_oe), .sense_en_i(sense_en), .scan_key_i(scan_key),
		.sense_key_i(sense_key), .ind_key_i(ind_key), .scan_pin_o(scan_i), .sense_pin_o(sense_i),
		.ind_pin_o(ind_i));
	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		if (err_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bound(input logic ok);
		if (ok !== 1'h1) begin
			chk("timeout", 32'h1, 32'h0);
			results();
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		repeat (200) begin
			@(posedge clk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
			if (bvalid === 1'h1) break;
		end
		bound(bvalid);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'h0;
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		repeat (200) begin
			@(posedge clk);
			if (arready === 1'h1) arvalid <= 1'h0;
			if (rvalid === 1'h1) break;
		end
		bound(rvalid);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk(nm, e, rdata);
		rready <= 1'h0;
	endtask
	task automatic span(ref logic s, input logic v, output int n);
		n = 0;
		repeat (100) begin
			@(posedge clk);
			if (s !== v) break;
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("reset_pins", 32'hA6FF, {scan_oe, scan_pd, kin_pd, sense_en, sense_pd, ind_oe, ind_o, ind_pd, scan_o});
		rd_chk("scan_reg", KEY_SCAN_PORT_REG_OFS, RESP_OKAY, 32'hFF);
		rd_chk("ctl0_reg", CARRIER_TIMER_CONTROL_REG_OFS, RESP_OKAY, 32'h03);
		rd_chk("ctl1_reg", PIN_MODE_CONTROL_REG_OFS, RESP_OKAY, 32'h26);
		axi_wr(KEY_SENSE_INPUT_REG_OFS, 8'h00, RESP_OKAY);
		rd_chk("key_sense", KEY_SENSE_INPUT_REG_OFS, RESP_OKAY, 32'hAF);
		rd_chk("unmapped_rd", 8'h20, RESP_SLVERR, 32'h0);
		axi_wr(8'h20, 8'h00, RESP_SLVERR);
	endtask
	task automatic t_masks();
		axi_wr(CARRIER_TIMER_CONTROL_REG_OFS, 8'hFF, RESP_OKAY);
		rd_chk("ctl0_mask", CARRIER_TIMER_CONTROL_REG_OFS, RESP_OKAY, 32'h3F);
		axi_wr(CARRIER_TIMER_CONTROL_REG_OFS, 8'h13, RESP_OKAY);
		chk("rom_hi", 32'h1, {30'h0, rom_hi});
		axi_wr(PIN_MODE_CONTROL_REG_OFS, 8'hFF, RESP_OKAY);
		rd_chk("ctl1_mask", PIN_MODE_CONTROL_REG_OFS, RESP_OKAY, 32'h37);
		chk("pins_37", 32'h5E, {scan_oe, scan_pd, kin_pd, sense_en, sense_pd, ind_oe, ind_pd});
		axi_wr(PIN_MODE_CONTROL_REG_OFS, 8'h10, RESP_OKAY);
		chk("pins_10", 32'h21, {scan_oe, scan_pd, kin_pd, sense_en, sense_pd, ind_oe, ind_pd});
	endtask
	task automatic t_ports();
		@(posedge clk);
		scan_key <= 8'h3C;
		ind_key <= 1'h1;
		kin <= 4'h5;
		axi_wr(KEY_SCAN_PORT_REG_OFS, 8'h5A, RESP_OKAY);
		chk("scan_latch", 32'h5A, {24'h0, scan_o});
		rd_chk("scan_pins", KEY_SCAN_PORT_REG_OFS, RESP_OKAY, 32'h3C);
		rd_chk("sense_off", KEY_SENSE_INPUT_REG_OFS, RESP_OKAY, 32'h5F);
		ind_key <= 1'h0;
		axi_wr(PIN_MODE_CONTROL_REG_OFS, 8'h01, RESP_OKAY);
		repeat (4) @(posedge clk);
		rd_chk("sense_in", KEY_SENSE_INPUT_REG_OFS, RESP_OKAY, 32'h53);
		axi_wr(PIN_MODE_CONTROL_REG_OFS, 8'h02, RESP_OKAY);
		rd_chk("scan_out", KEY_SCAN_PORT_REG_OFS, RESP_OKAY, 32'h5A);
	endtask
	task automatic t_carrier();
		int n, hi, lo;
		logic [31:0] ep;
		for (int c = 0; c < 8; c++) begin
			axi_wr(CARRIER_TIMER_CONTROL_REG_OFS, {4'h0, c[2], 1'h0, c[1:0]}, RESP_OKAY);
			ep = CLK_PER_OSC * (c[2] + 1) * ((c[1:0] == 0) ? 1 : (c[1:0] == 1) ? 8 : 12);
			span(carrier, 1'h1, n);
			span(carrier, 1'h0, n);
			span(carrier, 1'h1, n);
			span(carrier, 1'h0, n);
			span(carrier, 1'h1, hi);
			span(carrier, 1'h0, lo);
			chk("carrier_period", ep, hi + lo + 2);
			chk("carrier_high", (c[1:0] == 3) ? ep / 3 : ep / 2, hi + 1);
			span(tick, 1'h0, n);
			span(tick, 1'h0, n);
			chk("tick_period", 8 * CLK_PER_OSC * (c[2] + 1), n + 1);
		end
	endtask
	task automatic t_drive();
		int bad;
		bad = 0;
		axi_wr(CARRIER_TIMER_CONTROL_REG_OFS, 8'h04, RESP_OKAY);
		axi_wr(PIN_MODE_CONTROL_REG_OFS, 8'h26, RESP_OKAY);
		ind_key <= 1'h1;
		run <= 1'h1;
		oen <= 1'h1;
		repeat (4) @(posedge clk);
		rd_chk("ind_out_pin", KEY_SENSE_INPUT_REG_OFS, RESP_OKAY, 32'h57);
		repeat (20) begin
			@(posedge clk);
			if (drive !== 1'h1) bad++;
		end
		chk("drive_steady", 32'h0, bad);
		axi_wr(CARRIER_TIMER_CONTROL_REG_OFS, 8'h01, RESP_OKAY);
		repeat (40) begin
			@(posedge clk);
			if (drive !== carrier) bad++;
		end
		chk("drive_carrier", 32'h0, bad);
		run <= 1'h0;
		repeat (20) @(posedge clk);
		chk("drive_stop", 32'h1, {30'h0, drive, ind_o});
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		t_reset();
		t_masks();
		t_ports();
		t_carrier();
		t_drive();
		results();
	end
endmodule // tb_key_port_ctrl
